//--- logic/tcs_pkg.sv
/*
  constants, types and register map of the capture-mode timer channel.
  assumes a byte-addressed register port with 32-bit data words.
*/
package tcs_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL = 8'h60;
  localparam logic [7:0] OFF_MODE = 8'h64;
  localparam logic [7:0] OFF_STATUS = 8'h70;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h74;
  localparam logic [7:0] OFF_INT_DISABLE = 8'h78;
  localparam logic [7:0] OFF_INT_MASK = 8'h7C;
  localparam logic [7:0] OFF_COUNT = 8'h80;
  localparam logic [7:0] OFF_CAPTURE_A = 8'h84;
  localparam logic [7:0] OFF_CAPTURE_B = 8'h88;
  localparam logic [7:0] OFF_COMPARE_C = 8'h8C;

  // ---------------------------------------------------------------
  // control register bits
  // ---------------------------------------------------------------
  localparam int CR_SOFT_RESET = 0;
  localparam int CR_CLOCK_ENABLE = 1;
  localparam int CR_CLOCK_DISABLE = 2;
  localparam int CR_SOFT_TRIGGER = 3;

  // ---------------------------------------------------------------
  // mode register fields
  // ---------------------------------------------------------------
  localparam int MR_CLOCK_SEL_LO = 0;
  localparam int MR_CLOCK_INVERT = 3;
  localparam int MR_LOAD_B_STOPS = 6;
  localparam int MR_LOAD_B_DISABLES = 7;
  localparam int MR_TRIG_EDGE_LO = 8;
  localparam int MR_TRIG_PIN_SEL = 10;
  localparam int MR_COMPARE_TRIG = 14;
  localparam int MR_LOAD_A_EDGE_LO = 16;
  localparam int MR_LOAD_B_EDGE_LO = 18;
  localparam logic [31:0] MR_WRITABLE = 32'h000F_47CF;

  // ---------------------------------------------------------------
  // status, enable, disable and mask layout
  // ---------------------------------------------------------------
  localparam int SR_OVERFLOW = 0;
  localparam int SR_OVERRUN = 1;
  localparam int SR_COMPARE_C = 4;
  localparam int SR_LOAD_A = 5;
  localparam int SR_LOAD_B = 6;
  localparam int SR_EXT_TRIG = 7;
  localparam int SR_CLOCK_STATE = 8;
  localparam int SR_PIN_A_MIRROR = 9;
  localparam int SR_PIN_B_MIRROR = 10;
  localparam int SR_PIN_B_CHANGE = 16;
  localparam int SR_PIN_A_CHANGE = 17;
  localparam int SR_CLK_CHANGE = 18;
  localparam logic [31:0] SR_EVENT_MASK = 32'h0007_00F3;
  localparam logic [31:0] SR_CHANGE_MASK = 32'h0007_0000;

  // ---------------------------------------------------------------
  // counter and clock source
  // ---------------------------------------------------------------
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] DIV2_MASK = 10'h001;
  localparam logic [PRE_W-1:0] DIV8_MASK = 10'h007;
  localparam logic [PRE_W-1:0] DIV32_MASK = 10'h01F;
  localparam logic [PRE_W-1:0] DIV128_MASK = 10'h07F;
  localparam logic [PRE_W-1:0] DIV1024_MASK = 10'h3FF;
  localparam logic [2:0] CLKSEL_DIV2 = 3'h0;
  localparam logic [2:0] CLKSEL_DIV8 = 3'h1;
  localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
  localparam logic [2:0] CLKSEL_DIV128 = 3'h3;
  localparam logic [2:0] CLKSEL_DIV1024 = 3'h4;

  // pin vector indices
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_CLK = 2;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_EACH = 2'h3
  } tcs_edge_e;

  // gray order: off -> idle -> run
  typedef enum logic [1:0] {
    CNT_OFF = 2'h0,
    CNT_IDLE = 2'h1,
    CNT_RUN = 2'h3
  } tcs_cnt_e;

  typedef struct packed {
    tcs_edge_e load_b_edge_select;
    tcs_edge_e load_a_edge_select;
    logic compare_c_trigger;
    logic trigger_pin_select;
    tcs_edge_e trigger_edge_select;
    logic load_b_disables_clock;
    logic load_b_stops_counter;
    logic clock_invert;
    logic [2:0] clock_select;
  } tcs_mode_s;

endpackage : tcs_pkg

//--- logic/tcs_capture_regs.sv
/*
  capture-mode timer channel: counter, capture a/b, compare c, status,
  interrupt mask and register port.
  assumes a single-cycle strobe master on CLK_SYS and asynchronous pins.
*/
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module tcs_capture_regs (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic TIMER_PIN_A,
  input wire logic TIMER_PIN_B,
  input wire logic EXT_CLOCK_PIN,
  output logic IRQ
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic edge_match(input tcs_pkg::tcs_edge_e sel, input logic rise,
                                      input logic fall);
    logic hit;
    hit = 1'b0;
    case (sel)
      tcs_pkg::EDGE_RISE: hit = rise;
      tcs_pkg::EDGE_FALL: hit = fall;
      tcs_pkg::EDGE_EACH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_match

  function automatic tcs_pkg::tcs_mode_s decode_mode(input logic [31:0] m);
    tcs_pkg::tcs_mode_s r;
    r.load_b_edge_select = tcs_pkg::tcs_edge_e'(m[tcs_pkg::MR_LOAD_B_EDGE_LO +: 2]);
    r.load_a_edge_select = tcs_pkg::tcs_edge_e'(m[tcs_pkg::MR_LOAD_A_EDGE_LO +: 2]);
    r.compare_c_trigger = m[tcs_pkg::MR_COMPARE_TRIG];
    r.trigger_pin_select = m[tcs_pkg::MR_TRIG_PIN_SEL];
    r.trigger_edge_select = tcs_pkg::tcs_edge_e'(m[tcs_pkg::MR_TRIG_EDGE_LO +: 2]);
    r.load_b_disables_clock = m[tcs_pkg::MR_LOAD_B_DISABLES];
    r.load_b_stops_counter = m[tcs_pkg::MR_LOAD_B_STOPS];
    r.clock_invert = m[tcs_pkg::MR_CLOCK_INVERT];
    r.clock_select = m[tcs_pkg::MR_CLOCK_SEL_LO +: 3];
    return r;
  endfunction : decode_mode

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [2:0] sync1_q, sync2_q, sync3_q, level_q;
  logic [2:0] agree, pin_upd, pin_rise, pin_fall;
  logic [31:0] mode_q, imr_q, sts_q, flag_set, status_view;
  logic [15:0] cnt_q, compare_c_value, capture_a_value, capture_b_value, cnt_nx;
  logic [tcs_pkg::PRE_W-1:0] pre_q;
  tcs_pkg::tcs_cnt_e st_q;
  tcs_pkg::tcs_mode_s mode;
  logic a_unread_q, b_unread_q, pend_q;
  logic wr_cr, wr_mr, wr_ier, wr_idr, wr_rc, rd_sr, rd_ra, rd_rb;
  logic soft_rst, ch_rst, clk_en_cmd, clk_dis_cmd, soft_trig;
  logic tick, clk_on, running, ld_a_ev, ld_b_ev, ldb_off, ldb_stop, ldb_halt;
  logic halt_any, restart, advance, ovf_ev, cmp_ev, trig_pin_rise, trig_pin_fall;
  logic ext_trig_ev, trig_ev, ovr_ev;

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  always_comb begin
    wr_cr = 1'b0;
    wr_mr = 1'b0;
    wr_ier = 1'b0;
    wr_idr = 1'b0;
    wr_rc = 1'b0;
    if (WR && ADDR == tcs_pkg::OFF_CONTROL) begin
      wr_cr = 1'b1;
    end else if (WR && ADDR == tcs_pkg::OFF_MODE) begin
      wr_mr = 1'b1;
    end else if (WR && ADDR == tcs_pkg::OFF_INT_ENABLE) begin
      wr_ier = 1'b1;
    end else if (WR && ADDR == tcs_pkg::OFF_INT_DISABLE) begin
      wr_idr = 1'b1;
    end else if (WR && ADDR == tcs_pkg::OFF_COMPARE_C) begin
      wr_rc = 1'b1;
    end
  end

  assign rd_sr = RD && ADDR == tcs_pkg::OFF_STATUS;
  assign rd_ra = RD && ADDR == tcs_pkg::OFF_CAPTURE_A;
  assign rd_rb = RD && ADDR == tcs_pkg::OFF_CAPTURE_B;
  assign soft_rst = wr_cr && WDATA[tcs_pkg::CR_SOFT_RESET];
  assign ch_rst = SRST || soft_rst;
  assign clk_en_cmd = wr_cr && WDATA[tcs_pkg::CR_CLOCK_ENABLE];
  assign clk_dis_cmd = wr_cr && WDATA[tcs_pkg::CR_CLOCK_DISABLE];
  assign soft_trig = wr_cr && WDATA[tcs_pkg::CR_SOFT_TRIGGER];
  assign mode = decode_mode(mode_q);

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= {EXT_CLOCK_PIN, TIMER_PIN_B, TIMER_PIN_A};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a change counts once stages two and three agree
  assign agree = ~(sync2_q ^ sync3_q);
  assign pin_upd = agree & (sync3_q ^ level_q);
  assign pin_rise = pin_upd & sync3_q;
  assign pin_fall = pin_upd & ~sync3_q;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      level_q <= 3'h0;
    end else begin
      level_q <= (level_q & ~agree) | (sync3_q & agree);
    end
  end

  // ---------------------------------------------------------------
  // counter clock source
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always_comb begin
    case (mode.clock_select)
      tcs_pkg::CLKSEL_DIV2: tick = (pre_q & tcs_pkg::DIV2_MASK) == tcs_pkg::DIV2_MASK;
      tcs_pkg::CLKSEL_DIV8: tick = (pre_q & tcs_pkg::DIV8_MASK) == tcs_pkg::DIV8_MASK;
      tcs_pkg::CLKSEL_DIV32: tick = (pre_q & tcs_pkg::DIV32_MASK) == tcs_pkg::DIV32_MASK;
      tcs_pkg::CLKSEL_DIV128: tick = (pre_q & tcs_pkg::DIV128_MASK) == tcs_pkg::DIV128_MASK;
      tcs_pkg::CLKSEL_DIV1024: tick = pre_q == tcs_pkg::DIV1024_MASK;
      default: tick = mode.clock_invert ? pin_fall[tcs_pkg::PIN_CLK] :
                                          pin_rise[tcs_pkg::PIN_CLK];
    endcase
  end

  // ---------------------------------------------------------------
  // trigger, capture and counter events
  // ---------------------------------------------------------------
  assign clk_on = st_q != tcs_pkg::CNT_OFF;
  assign running = st_q == tcs_pkg::CNT_RUN;
  assign ld_a_ev = running && edge_match(mode.load_a_edge_select,
                   pin_rise[tcs_pkg::PIN_A], pin_fall[tcs_pkg::PIN_A]);
  assign ld_b_ev = running && edge_match(mode.load_b_edge_select,
                   pin_rise[tcs_pkg::PIN_B], pin_fall[tcs_pkg::PIN_B]);
  assign ldb_off = ld_b_ev && mode.load_b_disables_clock;
  assign ldb_stop = ld_b_ev && mode.load_b_stops_counter;
  assign ldb_halt = ldb_off || ldb_stop;
  assign trig_pin_rise = mode.trigger_pin_select ? pin_rise[tcs_pkg::PIN_A] :
                                                   pin_rise[tcs_pkg::PIN_B];
  assign trig_pin_fall = mode.trigger_pin_select ? pin_fall[tcs_pkg::PIN_A] :
                                                   pin_fall[tcs_pkg::PIN_B];
  assign ext_trig_ev = edge_match(mode.trigger_edge_select, trig_pin_rise,
                                  trig_pin_fall);
  assign halt_any = soft_rst || ldb_halt || clk_dis_cmd;
  assign restart = !halt_any && tick && clk_on && pend_q;
  assign advance = !halt_any && tick && running && !pend_q;
  assign cnt_nx = restart ? tcs_pkg::COUNT_ZERO : cnt_q + 16'h0001;
  assign ovf_ev = advance && cnt_q == tcs_pkg::COUNT_MAX;
  assign cmp_ev = (advance || restart) && cnt_nx == compare_c_value;
  assign trig_ev = ext_trig_ev || soft_trig || (cmp_ev && mode.compare_c_trigger);
  assign ovr_ev = (ld_a_ev && a_unread_q && !rd_ra) ||
                  (ld_b_ev && b_unread_q && !rd_rb);

  // ---------------------------------------------------------------
  // counter state and count
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (ch_rst) begin
      st_q <= tcs_pkg::CNT_OFF;
      cnt_q <= tcs_pkg::COUNT_ZERO;
    end else begin
      case (st_q)
        tcs_pkg::CNT_OFF: begin
          if (clk_en_cmd && !clk_dis_cmd) begin
            st_q <= tcs_pkg::CNT_IDLE;
          end
        end
        default: begin
          if (ldb_off || clk_dis_cmd) begin
            st_q <= tcs_pkg::CNT_OFF;
          end else if (ldb_stop) begin
            st_q <= tcs_pkg::CNT_IDLE;
          end else if (restart) begin
            st_q <= tcs_pkg::CNT_RUN;
          end
        end
      endcase
      if (restart || advance) begin
        cnt_q <= cnt_nx;
      end
    end
  end

  // pending trigger; a stop on the same edge cancels it
  always_ff @(posedge CLK_SYS) begin
    if (ch_rst) begin
      pend_q <= 1'b0;
    end else if (ldb_halt || clk_dis_cmd || !clk_on) begin
      pend_q <= 1'b0;
    end else if (trig_ev) begin
      pend_q <= 1'b1;
    end else if (restart) begin
      pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // capture registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (ch_rst) begin
      capture_a_value <= tcs_pkg::COUNT_ZERO;
      a_unread_q <= 1'b0;
    end else if (ld_a_ev) begin
      capture_a_value <= cnt_q;
      a_unread_q <= 1'b1;
    end else if (rd_ra) begin
      a_unread_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (ch_rst) begin
      capture_b_value <= tcs_pkg::COUNT_ZERO;
      b_unread_q <= 1'b0;
    end else if (ld_b_ev) begin
      capture_b_value <= cnt_q;
      b_unread_q <= 1'b1;
    end else if (rd_rb) begin
      b_unread_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // mode and compare registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (ch_rst) begin
      mode_q <= 32'h0000_0000;
    end else if (wr_mr) begin
      mode_q <= WDATA & tcs_pkg::MR_WRITABLE;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (ch_rst) begin
      compare_c_value <= tcs_pkg::COUNT_ZERO;
    end else if (wr_rc) begin
      compare_c_value <= WDATA[15:0];
    end
  end

  // ---------------------------------------------------------------
  // status flags and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    flag_set = 32'h0000_0000;
    flag_set[tcs_pkg::SR_OVERFLOW] = ovf_ev;
    flag_set[tcs_pkg::SR_OVERRUN] = ovr_ev;
    flag_set[tcs_pkg::SR_COMPARE_C] = cmp_ev;
    flag_set[tcs_pkg::SR_LOAD_A] = ld_a_ev;
    flag_set[tcs_pkg::SR_LOAD_B] = ld_b_ev;
    flag_set[tcs_pkg::SR_EXT_TRIG] = ext_trig_ev;
    flag_set[tcs_pkg::SR_PIN_A_CHANGE] = pin_upd[tcs_pkg::PIN_A];
    flag_set[tcs_pkg::SR_PIN_B_CHANGE] = pin_upd[tcs_pkg::PIN_B];
    flag_set[tcs_pkg::SR_CLK_CHANGE] = pin_upd[tcs_pkg::PIN_CLK];
  end

  // set wins over the read-clear
  always_ff @(posedge CLK_SYS) begin
    if (ch_rst) begin
      sts_q <= 32'h0000_0000;
    end else if (rd_sr) begin
      sts_q <= flag_set;
    end else begin
      sts_q <= sts_q | flag_set;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (ch_rst) begin
      imr_q <= 32'h0000_0000;
    end else if (wr_ier) begin
      imr_q <= imr_q | (WDATA & tcs_pkg::SR_EVENT_MASK);
    end else if (wr_idr) begin
      imr_q <= imr_q & ~(WDATA & tcs_pkg::SR_EVENT_MASK);
    end
  end

  assign IRQ = |(sts_q & imr_q);

  // change bits read inverted: zero means a change was seen
  always_comb begin
    status_view = sts_q ^ tcs_pkg::SR_CHANGE_MASK;
    status_view[tcs_pkg::SR_CLOCK_STATE] = clk_on;
    status_view[tcs_pkg::SR_PIN_A_MIRROR] = level_q[tcs_pkg::PIN_A];
    status_view[tcs_pkg::SR_PIN_B_MIRROR] = level_q[tcs_pkg::PIN_B];
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      RDATA <= 32'h0000_0000;
    end else if (!RD) begin
      RDATA <= 32'h0000_0000;
    end else if (ADDR == tcs_pkg::OFF_STATUS) begin
      RDATA <= status_view;
    end else if (ADDR == tcs_pkg::OFF_MODE) begin
      RDATA <= mode_q;
    end else if (ADDR == tcs_pkg::OFF_INT_MASK) begin
      RDATA <= imr_q;
    end else if (ADDR == tcs_pkg::OFF_COUNT) begin
      RDATA <= {16'h0000, cnt_q};
    end else if (ADDR == tcs_pkg::OFF_CAPTURE_A) begin
      RDATA <= {16'h0000, capture_a_value};
    end else if (ADDR == tcs_pkg::OFF_CAPTURE_B) begin
      RDATA <= {16'h0000, capture_b_value};
    end else if (ADDR == tcs_pkg::OFF_COMPARE_C) begin
      RDATA <= {16'h0000, compare_c_value};
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (ch_rst);

  read_clears_flags_a: assert property (
    rd_sr && flag_set == 32'h0000_0000 |=> sts_q == 32'h0000_0000)
    else $error("status read did not clear flags");
  overflow_flag_a: assert property (
    advance && cnt_q == tcs_pkg::COUNT_MAX |=> sts_q[tcs_pkg::SR_OVERFLOW] &&
    cnt_q == tcs_pkg::COUNT_ZERO)
    else $error("wrap did not set overflow");
  overrun_flag_a: assert property (
    ld_a_ev && a_unread_q && !rd_ra |=> sts_q[tcs_pkg::SR_OVERRUN])
    else $error("reload of unread capture a missed overrun");
  compare_flag_a: assert property (
    cmp_ev |=> sts_q[tcs_pkg::SR_COMPARE_C] && cnt_q == compare_c_value)
    else $error("compare match not flagged");
  load_b_capture_a: assert property (
    ld_b_ev |=> sts_q[tcs_pkg::SR_LOAD_B] && capture_b_value == $past(cnt_q))
    else $error("capture b load wrong");
  ext_trigger_a: assert property (
    ext_trig_ev |=> sts_q[tcs_pkg::SR_EXT_TRIG])
    else $error("trigger edge not flagged");
  change_reads_zero_a: assert property (
    rd_sr && sts_q[tcs_pkg::SR_PIN_A_CHANGE] |=> !RDATA[tcs_pkg::SR_PIN_A_CHANGE])
    else $error("pin a change bit not read as zero");
  mask_gates_irq_a: assert property (
    imr_q == 32'h0000_0000 |-> !IRQ)
    else $error("interrupt with all sources masked");
  enable_sets_mask_a: assert property (
    wr_ier && !soft_rst |=> (imr_q & $past(WDATA) & tcs_pkg::SR_EVENT_MASK) ==
    ($past(WDATA) & tcs_pkg::SR_EVENT_MASK))
    else $error("enable write did not set mask");
  restart_zero_a: assert property (
    restart |=> cnt_q == tcs_pkg::COUNT_ZERO && st_q == tcs_pkg::CNT_RUN)
    else $error("trigger did not zero and start counter");
  no_capture_idle_a: assert property (
    !running && !wr_cr |=> $stable(capture_a_value) && $stable(capture_b_value))
    else $error("capture while counter halted");
  load_b_halts_a: assert property (
    ldb_off |=> st_q == tcs_pkg::CNT_OFF && !status_view[tcs_pkg::SR_CLOCK_STATE])
    else $error("load b did not disable clock");

  overflow_seen_c: cover property (ovf_ev);
  compare_restart_c: cover property (cmp_ev && mode.compare_c_trigger ##[1:2] restart);
  load_b_stop_c: cover property (ldb_stop ##1 st_q == tcs_pkg::CNT_IDLE);
  overrun_seen_c: cover property (ovr_ev);

endmodule : tcs_capture_regs

//--- tb/tcs_pin_model.sv
/*
  pin-side partner: drives timer pin a, timer pin b and the external clock pin.
  assumes the bench calls pulse() from its own process on the same clock.
*/
`timescale 1ns/1ps
module tcs_pin_model (
  input wire logic clk,
  output logic pin_a,
  output logic pin_b,
  output logic ext_clk
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    ext_clk = 1'b0;
  end
  // each level held five clocks: wider than the synchroniser needs
  task automatic pulse(input int sel);
    for (int lvl = 1; lvl >= 0; lvl--) begin
      @(posedge clk);
      if (sel == 0) pin_a <= lvl[0];
      else if (sel == 1) pin_b <= lvl[0];
      else ext_clk <= lvl[0];
      repeat (4) @(posedge clk);
    end
  endtask : pulse
endmodule : tcs_pin_model

//--- tb/tcs_capture_regs_tb.sv
/*
  self-checking bench of the capture-mode timer channel.
  assumes the pin partner model and the package from the logic folder.
*/
`timescale 1ns/1ps
module tcs_capture_regs_tb;
  logic clk_sys, srst, wr, rd, irq, pa, pb, pc;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, s, c1;
  int bad_count = 0;
  int checks = 0;
  tcs_capture_regs dut (.CLK_SYS(clk_sys), .SRST(srst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .TIMER_PIN_A(pa), .TIMER_PIN_B(pb),
    .EXT_CLOCK_PIN(pc), .IRQ(irq));
  tcs_pin_model pins (.clk(clk_sys), .pin_a(pa), .pin_b(pb), .ext_clk(pc));
  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rreg
  function automatic logic [31:0] sb(input int b);
    return 32'(s[b]);
  endfunction : sb
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task automatic report_and_stop;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("status", tcs_pkg::SR_CHANGE_MASK, s);
    rreg(tcs_pkg::OFF_COUNT, s);
    chk("count", 32'h0000_0000, s);
    rreg(8'h90, s);
    chk("unmapped", 32'h0000_0000, s);
  endtask : t_reset
  task automatic t_mask;
    wreg(tcs_pkg::OFF_INT_ENABLE, 32'hFFFF_FFFF);
    rreg(tcs_pkg::OFF_INT_MASK, s);
    chk("mask all", tcs_pkg::SR_EVENT_MASK, s);
    wreg(tcs_pkg::OFF_INT_DISABLE, 32'h0007_00D3);
    wreg(tcs_pkg::OFF_INT_ENABLE, 32'h0000_0000);
    rreg(tcs_pkg::OFF_INT_MASK, s);
    chk("mask load a", 32'h0000_0020, s);
  endtask : t_mask
  task automatic t_run;
    wreg(tcs_pkg::OFF_COMPARE_C, 32'h0000_0005);
    wreg(tcs_pkg::OFF_MODE, 32'h0001_4000);
    wreg(8'h60, 32'h0000_0002);
    wreg(8'h60, 32'h0000_0008);
    wt(40);
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("clock state", 1, sb(tcs_pkg::SR_CLOCK_STATE));
    chk("compare", 1, sb(tcs_pkg::SR_COMPARE_C));
    chk("irq idle", 0, 32'(irq));
    rreg(tcs_pkg::OFF_COUNT, s);
    chk("count wraps", 1, 32'(s <= 32'h0000_0005));
  endtask : t_run
  task automatic t_capture;
    pins.pulse(0);
    pins.pulse(2);
    wt(8);
    chk("irq", 1, 32'(irq));
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("load a", 1, sb(tcs_pkg::SR_LOAD_A));
    chk("pin a chg", 0, sb(tcs_pkg::SR_PIN_A_CHANGE));
    chk("clk chg", 0, sb(tcs_pkg::SR_CLK_CHANGE));
    chk("pin b chg", 1, sb(tcs_pkg::SR_PIN_B_CHANGE));
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("load a clr", 0, sb(tcs_pkg::SR_LOAD_A));
    chk("pin a clr", 1, sb(tcs_pkg::SR_PIN_A_CHANGE));
    chk("irq clr", 0, 32'(irq));
    rreg(tcs_pkg::OFF_CAPTURE_A, s);
    chk("cap a", 1, 32'(s <= 32'h0000_0005));
    pins.pulse(0);
    pins.pulse(0);
    wt(8);
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("overrun", 1, sb(tcs_pkg::SR_OVERRUN));
    rreg(tcs_pkg::OFF_CAPTURE_A, s);
    pins.pulse(0);
    wt(8);
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("no overrun", 0, sb(tcs_pkg::SR_OVERRUN));
  endtask : t_capture
  task automatic t_stop;
    wreg(tcs_pkg::OFF_MODE, 32'h0008_4040);
    pins.pulse(1);
    wt(8);
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("load b", 1, sb(tcs_pkg::SR_LOAD_B));
    rreg(tcs_pkg::OFF_COUNT, c1);
    wt(10);
    rreg(tcs_pkg::OFF_COUNT, s);
    chk("count held", c1, s);
    rreg(tcs_pkg::OFF_CAPTURE_B, s);
    chk("cap b", 1, 32'(s <= 32'h0000_0005));
    wreg(tcs_pkg::OFF_MODE, 32'h0008_4080);
    wreg(8'h60, 32'h0000_0008);
    wt(10);
    pins.pulse(1);
    wt(8);
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("clock off", 0, sb(tcs_pkg::SR_CLOCK_STATE));
    wreg(tcs_pkg::OFF_MODE, 32'h0001_4000);
    pins.pulse(0);
    wt(8);
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("no load", 0, sb(tcs_pkg::SR_LOAD_A));
  endtask : t_stop
  task automatic t_trig;
    wreg(8'h60, 32'h0000_0002);
    wreg(tcs_pkg::OFF_MODE, 32'h0000_4500);
    pins.pulse(1);
    wt(8);
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("trig pin b", 0, sb(tcs_pkg::SR_EXT_TRIG));
    pins.pulse(0);
    wt(8);
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("trig pin a", 1, sb(tcs_pkg::SR_EXT_TRIG));
    rreg(tcs_pkg::OFF_COUNT, s);
    chk("count run", 1, 32'(s <= 32'h0000_0005));
    c1 = s;
    rreg(tcs_pkg::OFF_COUNT, s);
    chk("count moves", 1, 32'(s != c1));
  endtask : t_trig
  // external clock pin, inverted, and capture a on each edge
  task automatic t_each;
    rreg(tcs_pkg::OFF_CAPTURE_A, s);
    wreg(tcs_pkg::OFF_MODE, 32'h0003_000D);
    wreg(tcs_pkg::OFF_CONTROL, 32'h0000_0008);
    repeat (4) pins.pulse(2);
    rreg(tcs_pkg::OFF_COUNT, s);
    chk("ext count", 32'h0000_0003, s);
    rreg(tcs_pkg::OFF_STATUS, s);
    pins.pulse(0);
    wt(8);
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("each edge", 1, sb(tcs_pkg::SR_OVERRUN));
    rreg(tcs_pkg::OFF_CAPTURE_A, s);
    chk("cap a ext", 32'h0000_0003, s);
  endtask : t_each
  // second reset in mid-run
  task automatic t_sreset;
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rreg(tcs_pkg::OFF_INT_MASK, s);
    chk("mask rst", 32'h0000_0000, s);
    rreg(tcs_pkg::OFF_STATUS, s);
    chk("status rst", tcs_pkg::SR_CHANGE_MASK, s);
    rreg(tcs_pkg::OFF_COUNT, s);
    chk("count rst", 32'h0000_0000, s);
  endtask : t_sreset
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
  initial begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_mask();
    t_run();
    t_capture();
    t_stop();
    t_trig();
    t_each();
    t_sreset();
    report_and_stop();
  end
endmodule : tcs_capture_regs_tb
